/* File: sim/lcb_cpu_model.sv */
module lcb_cpu_model (
    input  wire         clk_in,
    input  wire         bus_ack_in,
    input  wire         bus_err_in,
    input  wire  [31:0] bus_rdata_in,
    output logic        bus_req_out,
    output logic        bus_wr_out,
    output logic [2:0]  bus_space_out,
    output logic [6:0]  bus_addr_out,
    output logic [1:0]  bus_size_out,
    output logic [31:0] bus_wdata_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        bus_req_out   = 1'h0;
        bus_wr_out    = 1'h0;
        bus_space_out = 3'h0;
        bus_addr_out  = 7'h0;
        bus_size_out  = 2'h0;
        bus_wdata_out = 32'h0;
    end
    // No fifo, running count or fifo-loaded data access is ever issued
    task automatic access(input logic wr, input logic [2:0] sp,
        input logic [6:0] ad, input logic [1:0] sz, input logic [31:0] wd,
        output logic [31:0] rd, output logic ef, output logic seen);
        int n;
        @(posedge clk_in);
        #1;
        bus_req_out   = 1'h1;
        bus_wr_out    = wr;
        bus_space_out = sp;
        bus_addr_out  = ad;
        bus_size_out  = sz;
        bus_wdata_out = wd;
        @(posedge clk_in);
        #1;
        bus_req_out   = 1'h0;
        // Released lines must not keep looking valid
        bus_addr_out  = ~ad;
        bus_wdata_out = ~wd;
        seen = 1'h0;
        for (n = 0; n < 3 && seen == 1'h0; n++)
        begin
            if (bus_ack_in === 1'h1)
                seen = 1'h1;
            else
                @(posedge clk_in) #1;
        end
        rd = bus_rdata_in;
        ef = bus_err_in;
    endtask
endmodule // lcb_cpu_model

/* File: sim/lcb_reset_access_monitor.sv */
module lcb_reset_access_monitor (
    input wire        clk_in,
    input wire        resetn_in,
    input wire [31:0] route_in,
    input wire        bus_req_in,
    input wire        bus_wr_in,
    input wire [2:0]  bus_space_in,
    input wire [6:0]  bus_addr_in,
    input wire [1:0]  bus_size_in,
    input wire [31:0] bus_wdata_in,
    input wire [31:0] route_out,
    input wire [31:0] bus_rdata_out,
    input wire        bus_ack_out,
    input wire        bus_err_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking mon_cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    sequence cfg_wr8_s;
        bus_req_in && bus_wr_in && bus_space_in == 3'h4 && bus_size_in == 2'h0;
    endsequence
    sequence cfg_rd8_s;
        bus_req_in && !bus_wr_in && bus_space_in == 3'h4 && bus_size_in == 2'h0
            && bus_addr_in == $past(bus_addr_in, 2);
    endsequence
    ack_after_req_a: assert property (bus_req_in |=> bus_ack_out)
        else $error("no acknowledge one cycle after a request");
    ack_only_req_a: assert property (!bus_req_in |=> !bus_ack_out)
        else $error("acknowledge without a request");
    err_needs_ack_a: assert property (bus_err_out |-> bus_ack_out)
        else $error("error flag without acknowledge");
    idle_rdata_a: assert property (!bus_ack_out
        |-> bus_rdata_out == 32'h0)
        else $error("read data outside an answer");
    w8_one_lane_a: assert property (bus_req_in && !bus_wr_in
        && bus_space_in == 3'h0 |=> bus_rdata_out[31:8] == 24'h0)
        else $error("byte read returned upper lanes");
    bad_index_a: assert property (bus_req_in
        && bus_space_in == 3'h0
        && bus_addr_in[3:0] > 4'hA |=> bus_err_out && bus_rdata_out == 32'h0)
        else $error("unmapped register not refused");
    good_index_a: assert property (bus_req_in
        && bus_space_in == 3'h0
        && bus_addr_in[3:0] <= 4'hA |=> !bus_err_out)
        else $error("mapped register refused");
    bad_space_a: assert property (bus_req_in
        && bus_space_in > 3'h4 |=> bus_err_out)
        else $error("unmapped space not refused");
    cfg_echo_a: assert property (cfg_wr8_s ##2 cfg_rd8_s
        |=> bus_rdata_out == ($past(bus_wdata_in, 3) & 32'h000000FF))
        else $error("latch byte did not read back");
    por_quiet_a: assert property (disable iff (1'b0) !resetn_in
        |-> route_out == 32'h0 && !bus_ack_out && !bus_err_out)
        else $error("outputs not held low in reset");
endmodule // lcb_reset_access_monitor

bind lcb_reset_access lcb_reset_access_monitor mon (
    .clk_in(clk_in), .resetn_in(resetn_in), .route_in(route_in),
    .bus_req_in(bus_req_in), .bus_wr_in(bus_wr_in),
    .bus_space_in(bus_space_in), .bus_addr_in(bus_addr_in),
    .bus_size_in(bus_size_in), .bus_wdata_in(bus_wdata_in),
    .route_out(route_out), .bus_rdata_out(bus_rdata_out),
    .bus_ack_out(bus_ack_out), .bus_err_out(bus_err_out)
);

/* File: sim/lcb_reset_access_tb_top.sv */
module lcb_reset_access_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic        wr;
        logic [2:0]  sp;
        logic [6:0]  ad;
        logic [1:0]  sz;
        logic [31:0] wd;
        logic [31:0] ex;
        logic        er;
    } lcb_row_t;
    localparam int NROWS = 20;
    logic        clk_in;
    logic        resetn_in;
    logic [31:0] route_in;
    wire         bus_req;
    wire         bus_wr;
    wire [2:0]   bus_space;
    wire [6:0]   bus_addr;
    wire [1:0]   bus_size;
    wire [31:0]  bus_wdata;
    wire [31:0]  route_out;
    wire [31:0]  bus_rdata;
    wire         bus_ack;
    wire         bus_err;
    int          fails = 0;
    int          comparisons = 0;
    lcb_row_t    rows [NROWS] = '{
        '{1'h0, 3'h0, 7'h00, 2'h0, 32'h0, 32'h0, 1'h0},
        '{1'h0, 3'h4, 7'h1F, 2'h0, 32'h0, 32'h0, 1'h0},
        '{1'h0, 3'h0, 7'h09, 2'h0, 32'h0, 32'h0, 1'h0},
        '{1'h1, 3'h0, 7'h10, 2'h0, 32'h5A, 32'h0, 1'h0},
        '{1'h0, 3'h0, 7'h10, 2'h0, 32'h0, 32'h5A, 1'h0},
        '{1'h1, 3'h1, 7'h21, 2'h0, 32'hC3B7, 32'h0, 1'h0},
        '{1'h0, 3'h0, 7'h31, 2'h0, 32'h0, 32'hC3, 1'h0},
        '{1'h0, 3'h1, 7'h31, 2'h0, 32'h0, 32'hC3, 1'h0},
        '{1'h1, 3'h2, 7'h00, 2'h0, 32'h2211, 32'h0, 1'h0},
        '{1'h0, 3'h2, 7'h00, 2'h0, 32'h0, 32'h2211, 1'h0},
        '{1'h1, 3'h3, 7'h08, 2'h0, 32'h44332211, 32'h0, 1'h0},
        '{1'h0, 3'h0, 7'h28, 2'h0, 32'h0, 32'h33, 1'h0},
        '{1'h1, 3'h4, 7'h20, 2'h2, 32'hDDCCBBAA, 32'h0, 1'h0},
        '{1'h0, 3'h4, 7'h21, 2'h1, 32'h0, 32'hCCBB, 1'h0},
        '{1'h1, 3'h4, 7'h7C, 2'h0, 32'hA5, 32'h0, 1'h0},
        '{1'h0, 3'h4, 7'h7C, 2'h0, 32'h0, 32'hA5, 1'h0},
        '{1'h0, 3'h0, 7'h0B, 2'h0, 32'h0, 32'h0, 1'h1},
        '{1'h0, 3'h5, 7'h00, 2'h0, 32'h0, 32'h0, 1'h1},
        '{1'h1, 3'h0, 7'h06, 2'h0, 32'hFF, 32'h0, 1'h0},
        '{1'h0, 3'h0, 7'h06, 2'h0, 32'h0, 32'h0, 1'h0}
    };
    lcb_reset_access dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .route_in(route_in),
        .bus_req_in(bus_req), .bus_wr_in(bus_wr), .bus_space_in(bus_space),
        .bus_addr_in(bus_addr), .bus_size_in(bus_size),
        .bus_wdata_in(bus_wdata), .route_out(route_out),
        .bus_rdata_out(bus_rdata), .bus_ack_out(bus_ack),
        .bus_err_out(bus_err)
    );
    lcb_cpu_model cpu (
        .clk_in(clk_in), .bus_ack_in(bus_ack), .bus_err_in(bus_err),
        .bus_rdata_in(bus_rdata), .bus_req_out(bus_req),
        .bus_wr_out(bus_wr), .bus_space_out(bus_space),
        .bus_addr_out(bus_addr), .bus_size_out(bus_size),
        .bus_wdata_out(bus_wdata)
    );
    initial
    begin
        clk_in = 1'h0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic xfer(input logic wr, input logic [2:0] sp,
        input logic [6:0] ad, input logic [1:0] sz, input logic [31:0] wd,
        input logic [31:0] ex, input logic er);
        logic [31:0] rd;
        logic        ef;
        logic        seen;
        cpu.access(wr, sp, ad, sz, wd, rd, ef, seen);
        if (seen !== 1'h1)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, seen, 1'h1);
            fails++;
            report_and_stop();
        end
        else
        begin
            check(rd, ex);
            check({31'h0, ef}, {31'h0, er});
        end
    endtask
    task automatic reg_wr(input logic [6:0] ad, input logic [7:0] wd);
        xfer(1'h1, 3'h0, ad, 2'h0, {24'h0, wd}, 32'h0, 1'h0);
    endtask
    task automatic reg_rd(input logic [6:0] ad, input logic [7:0] ex);
        xfer(1'h0, 3'h0, ad, 2'h0, 32'h0, {24'h0, ex}, 1'h0);
    endtask
    task automatic cfg_wr(input logic [6:0] ad, input logic [7:0] wd);
        xfer(1'h1, 3'h4, ad, 2'h0, {24'h0, wd}, 32'h0, 1'h0);
    endtask
    task automatic pulse(input int b);
        @(posedge clk_in);
        #1;
        route_in[b] = 1'h1;
        @(posedge clk_in);
        #1;
        route_in[b] = 1'h0;
    endtask
    initial
    begin
        route_in  = 32'h0;
        resetn_in = 1'h0;
        repeat (12) @(posedge clk_in);
        check(route_out, 32'h0);
        #1;
        resetn_in = 1'h1;
        for (int i = 0; i < NROWS; i++)
            xfer(rows[i].wr, rows[i].sp, rows[i].ad, rows[i].sz,
                rows[i].wd, rows[i].ex, rows[i].er);
        $display("Table rows done");
        reg_wr(7'h02, 8'h77);
        cfg_wr(7'h1F, 8'h04);
        cfg_wr(7'h1F, 8'h00);
        reg_rd(7'h00, 8'h00);
        reg_rd(7'h02, 8'h00);
        reg_rd(7'h08, 8'h11);
        $display("Firmware reset test done");
        cfg_wr(7'h1F, 8'h02);
        cfg_wr(7'h1E, 8'h24);
        reg_wr(7'h00, 8'h55);
        reg_wr(7'h02, 8'h66);
        reg_wr(7'h07, 8'h09);
        pulse(0);
        reg_rd(7'h07, 8'h00);
        reg_rd(7'h00, 8'h55);
        cfg_wr(7'h1F, 8'h03);
        pulse(0);
        reg_rd(7'h00, 8'h00);
        reg_rd(7'h02, 8'h66);
        reg_rd(7'h08, 8'h11);
        $display("Routed reset test done");
        reg_wr(7'h11, 8'h01);
        pulse(13);
        reg_rd(7'h11, 8'h01);
        cfg_wr(7'h3F, 8'h02);
        pulse(13);
        reg_rd(7'h11, 8'h02);
        check(route_out, 32'h1010_1A10);
        $display("Routing gate test done");
        @(posedge clk_in);
        #1;
        resetn_in = 1'h0;
        repeat (3) @(posedge clk_in);
        check(route_out, 32'h0);
        #1;
        resetn_in = 1'h1;
        reg_rd(7'h10, 8'h00);
        reg_rd(7'h08, 8'h00);
        xfer(1'h0, 3'h4, 7'h3F, 2'h0, 32'h0, 32'h0, 1'h0);
        $display("Second reset test done");
        report_and_stop();
    end
endmodule // lcb_reset_access_tb_top

/* File: src/lcb_consts.vh */
`ifndef LCB_CONSTS_VH
`define LCB_CONSTS_VH

// Address spaces
`define LCB_SP_W8        3'h0
`define LCB_SP_W16C      3'h1
`define LCB_SP_W16P      3'h2
`define LCB_SP_W32       3'h3
`define LCB_SP_CFG       3'h4

// Access size for the configuration space
`define LCB_SZ_8         2'h0
`define LCB_SZ_16        2'h1
`define LCB_SZ_32        2'h2

// Working register indices
`define LCB_R_ACC0       5'h00
`define LCB_R_ACC1       5'h01
`define LCB_R_DAT0       5'h02
`define LCB_R_DAT1       5'h03
`define LCB_R_FIFO0      5'h04
`define LCB_R_FIFO1      5'h05
`define LCB_R_STAT       5'h06
`define LCB_R_COUNT      5'h07
`define LCB_R_PERIOD     5'h08
`define LCB_R_AUXCTL     5'h09
`define LCB_R_MCELL      5'h0A

// Configuration latch indices
`define LCB_CFG_LAST     5'h1F
`define LCB_CFG_RSEL     5'h1E
`define LCB_CFG_RSEL2    5'h1D

// config_latch_last fields
`define LCB_ALT_BIT      0
`define LCB_ROUTE_EN_BIT 1
`define LCB_FW_RST_BIT   2
// Reset select latch fields
`define LCB_ARR_SEL_LO   0
`define LCB_ARR_SEL_HI   1
`define LCB_ARR_EN_BIT   2
`define LCB_DU_SEL_LO    3
`define LCB_DU_SEL_HI    4
`define LCB_DU_EN_BIT    5
`define LCB_CU_SEL_LO    6
`define LCB_CU_SEL_HI    7
// Second reset select latch fields
`define LCB_CU_EN_BIT    0
`define LCB_SR_EN_BIT    1
// Auxiliary control fields
`define LCB_AUX_START    0
`define LCB_AUX_DLOAD    1
// Per-block routing input fields
`define LCB_RI_RST_HI    3
`define LCB_RI_ADD       4
`define LCB_RI_SHIFT     5
`define LCB_RI_SIN       6
`define LCB_RI_POP       7

`define LCB_BYTE_ZERO    8'h00
`define LCB_FIFO_DEPTH   3'h4

`endif

/* File: src/lcb_reset_access.v */
// Function
// - reset_scheme_select 0 is the compatible, 1 the alternate scheme.
// - Compatible: one shared routed reset for macrocells and the counter.
// - Compatible: firmware reset clears outputs, flags, fifo, accs, data.
// - Data registers retain through sleep; fifo data is unknown RAM.
// - Mask/period and auxiliary control retain in both schemes.
// - Compatible: status register and datapath have no routed reset.
// - Alternate: each component selects its own reset source.
// - Alternate: status may use control reset; datapath its own reset.
// - Alternate: datapath routed reset clears all but the data registers.
// - Alternate: first logic array settings govern both logic arrays.
// - Power-on clears latches, accs, data, aux, mask, status, macrocells.
// - Configuration RAM is cleared on power-on; fifo RAM is unknown.
// - Outputs into routing are held at zero on power-on.
// - Routing inputs are gated to zero after power-on.
// - 8-bit space reaches each working register of one block.
// - 16-bit consecutive space: one register in two adjacent blocks.
// - 16-bit paired space reaches two registers of one block.
// - 32-bit space spans four blocks; configuration at 8, 16, 32 bits.
// - Internal plus bus write: the bus write wins; internal read sees old value.
// - Fifo-loaded data registers take only fifo writes; no bus read.
module lcb_reset_access #(
    parameter NBLK = 4
) (
    input  wire        clk_in,
    input  wire        resetn_in,
    input  wire [31:0] route_in,
    input  wire        bus_req_in,
    input  wire        bus_wr_in,
    input  wire [2:0]  bus_space_in,
    input  wire [6:0]  bus_addr_in,
    input  wire [1:0]  bus_size_in,
    input  wire [31:0] bus_wdata_in,
    output reg  [31:0] route_out,
    output reg  [31:0] bus_rdata_out,
    output reg         bus_ack_out,
    output reg         bus_err_out
);
`include "lcb_consts.vh"

    // Lane k of the bus word maps to one byte register: {ok, blk, idx}
    function [7:0] lcb_lane;
        input [2:0] sp;
        input [6:0] a;
        input [1:0] sz;
        input [1:0] k;
        reg   [2:0] bsum;
        reg   [4:0] rsum;
        reg   [5:0] csum;
        begin
            lcb_lane = `LCB_BYTE_ZERO;
            bsum = {1'b0, a[5:4]} + {1'b0, k};
            rsum = {1'b0, a[3:0]} + {3'b000, k};
            csum = {1'b0, a[4:0]} + {4'b0000, k};
            case (sp)
                `LCB_SP_W8:
                    if (k == 2'h0)
                        lcb_lane = {1'b1, a[5:4], 1'b0, a[3:0]};
                `LCB_SP_W16C:
                    if (k < 2'h2 && !bsum[2])
                        lcb_lane = {1'b1, bsum[1:0], 1'b0, a[3:0]};
                `LCB_SP_W16P:
                    if (k < 2'h2)
                        lcb_lane = {1'b1, a[5:4], rsum};
                `LCB_SP_W32:
                    lcb_lane = {1'b1, k, 1'b0, a[3:0]};
                `LCB_SP_CFG:
                    if (!csum[5] && (sz == `LCB_SZ_32
                        || (sz == `LCB_SZ_16 && k < 2'h2)
                        || (sz == `LCB_SZ_8 && k == 2'h0)))
                        lcb_lane = {1'b1, a[6:5], csum[4:0]};
                default:
                    lcb_lane = `LCB_BYTE_ZERO;
            endcase
            if (sp != `LCB_SP_CFG && lcb_lane[4:0] > `LCB_R_MCELL)
                lcb_lane = `LCB_BYTE_ZERO;
        end
    endfunction

    reg  [7:0] cfg_reg    [0:127];
    reg  [7:0] acc0_reg   [0:NBLK-1];
    reg  [7:0] acc1_reg   [0:NBLK-1];
    reg  [7:0] dat0_reg   [0:NBLK-1];
    reg  [7:0] dat1_reg   [0:NBLK-1];
    reg  [7:0] count_reg  [0:NBLK-1];
    reg  [7:0] period_reg [0:NBLK-1];
    reg  [7:0] aux_reg    [0:NBLK-1];
    reg  [7:0] stat_reg   [0:NBLK-1];
    reg  [7:0] mcell_reg  [0:NBLK-1];
    // No reset on fifo storage: it is RAM and powers up unknown
    reg  [7:0] fifo_mem   [0:31];
    reg  [2:0] wptr_reg   [0:7];
    reg  [2:0] rptr_reg   [0:7];
    reg  [3:0] carry_reg;
    reg  [3:0] sout_reg;
    reg  [3:0] tc_reg;

    reg  [31:0] lane_v;
    reg  [31:0] rin_v;
    reg  [31:0] rd_v;
    reg  [3:0]  arr_rst_v;
    reg  [3:0]  cu_rst_v;
    reg  [3:0]  sr_rst_v;
    reg  [3:0]  du_rst_v;
    reg  [3:0]  fw_rst_v;
    reg  [3:0]  dload_v;
    reg  [7:0]  push_v;
    reg  [7:0]  bpop_v;
    reg  [7:0]  ipop_v;
    reg  [7:0]  full_v;
    reg  [7:0]  empty_v;
    reg  [7:0]  push_dat [0:7];
    reg  [7:0]  c_last;
    reg  [7:0]  c_rsel;
    reg  [7:0]  c_rsel2;
    reg  [3:0]  rc;
    reg  [2:0]  fidx;
    reg  [1:0]  lb;
    reg  [4:0]  li;
    reg  [2:0]  lvl;
    reg         pr;
    reg         dpr;
    reg         scr;

    wire        bus_wr = bus_req_in & bus_wr_in;
    wire        bus_rd = bus_req_in & ~bus_wr_in;

    // Lane decode, routing gate, reset selection, fifo flags, read mux
    always @*
    begin : comb_p
        integer b, k, m;
        b = 0;
        k = 0;
        m = 0;
        lane_v = 32'h0000_0000;
        rin_v = 32'h0000_0000;
        for (k = 0; k < 4; k = k + 1)
            lane_v[k*8 +: 8] = lcb_lane(bus_space_in, bus_addr_in,
                                        bus_size_in, k[1:0]);
        for (b = 0; b < NBLK; b = b + 1)
        begin
            c_last  = cfg_reg[{b[1:0], `LCB_CFG_LAST}];
            c_rsel  = cfg_reg[{b[1:0], `LCB_CFG_RSEL}];
            c_rsel2 = cfg_reg[{b[1:0], `LCB_CFG_RSEL2}];
            // Nothing from routing reaches the block until enabled
            if (c_last[`LCB_ROUTE_EN_BIT])
                rin_v[b*8 +: 8] = route_in[b*8 +: 8];
            rc  = rin_v[b*8 +: 4];
            // Only the first array's select exists, it serves both
            pr  = c_rsel[`LCB_ARR_EN_BIT]
                & rc[c_rsel[`LCB_ARR_SEL_HI:`LCB_ARR_SEL_LO]];
            dpr = c_rsel[`LCB_DU_EN_BIT]
                & rc[c_rsel[`LCB_DU_SEL_HI:`LCB_DU_SEL_LO]];
            scr = c_rsel2[`LCB_CU_EN_BIT]
                & rc[c_rsel[`LCB_CU_SEL_HI:`LCB_CU_SEL_LO]];
            fw_rst_v[b]  = c_last[`LCB_FW_RST_BIT];
            arr_rst_v[b] = pr;
            dload_v[b]   = aux_reg[b][`LCB_AUX_DLOAD];
            if (c_last[`LCB_ALT_BIT])
            begin
                cu_rst_v[b] = scr;
                sr_rst_v[b] = scr & c_rsel2[`LCB_SR_EN_BIT];
                du_rst_v[b] = dpr | fw_rst_v[b];
            end
            else
            begin
                cu_rst_v[b] = pr;
                sr_rst_v[b] = 1'b0;
                du_rst_v[b] = fw_rst_v[b];
            end
        end
        for (m = 0; m < 8; m = m + 1)
        begin
            lvl = wptr_reg[m] - rptr_reg[m];
            full_v[m]  = (lvl == `LCB_FIFO_DEPTH);
            empty_v[m] = (lvl == 3'h0);
            push_v[m] = 1'b0;
            bpop_v[m] = 1'b0;
            push_dat[m] = `LCB_BYTE_ZERO;
            // Internal side only reads the fifos, the bus fills them
            ipop_v[m] = rin_v[(m/2)*8 + `LCB_RI_POP] & dload_v[m/2]
                      & ~empty_v[m];
        end
        for (k = 0; k < 4; k = k + 1)
        begin
            lb = lane_v[k*8+5 +: 2];
            li = lane_v[k*8 +: 5];
            fidx = {lb, li[0]};
            if (lane_v[k*8+7] && bus_space_in != `LCB_SP_CFG
                && (li == `LCB_R_FIFO0 || li == `LCB_R_FIFO1))
            begin
                push_v[fidx] = bus_wr & ~full_v[fidx];
                bpop_v[fidx] = bus_rd & ~empty_v[fidx];
                push_dat[fidx] = bus_wdata_in[k*8 +: 8];
            end
        end
        // Bus read mux; flops give the current value to every reader
        rd_v = 32'h0000_0000;
        for (k = 0; k < 4; k = k + 1)
        begin
            lb = lane_v[k*8+5 +: 2];
            li = lane_v[k*8 +: 5];
            fidx = {lb, li[0]};
            if (lane_v[k*8+7])
            begin
                if (bus_space_in == `LCB_SP_CFG)
                    rd_v[k*8 +: 8] = cfg_reg[{lb, li}];
                else
                    case (li)
                        `LCB_R_ACC0:   rd_v[k*8 +: 8] = acc0_reg[lb];
                        `LCB_R_ACC1:   rd_v[k*8 +: 8] = acc1_reg[lb];
                        // Fifo-loaded data registers read as zero
                        `LCB_R_DAT0:   rd_v[k*8 +: 8] =
                            dload_v[lb] ? `LCB_BYTE_ZERO
                                        : dat0_reg[lb];
                        `LCB_R_DAT1:   rd_v[k*8 +: 8] =
                            dload_v[lb] ? `LCB_BYTE_ZERO
                                        : dat1_reg[lb];
                        `LCB_R_FIFO0,
                        `LCB_R_FIFO1:  rd_v[k*8 +: 8] =
                            fifo_mem[{fidx, rptr_reg[fidx][1:0]}];
                        `LCB_R_STAT:   rd_v[k*8 +: 8] = stat_reg[lb];
                        // Safe only with the counter stopped
                        `LCB_R_COUNT:  rd_v[k*8 +: 8] =
                            count_reg[lb];
                        `LCB_R_PERIOD: rd_v[k*8 +: 8] = period_reg[lb];
                        `LCB_R_AUXCTL: rd_v[k*8 +: 8] = aux_reg[lb];
                        `LCB_R_MCELL:  rd_v[k*8 +: 8] = mcell_reg[lb];
                        default:       rd_v[k*8 +: 8] = `LCB_BYTE_ZERO;
                    endcase
            end
        end
    end

    // Fifo RAM, deliberately outside the reset domain
    always @(posedge clk_in)
    begin : fifo_p
        integer m;
        for (m = 0; m < 8; m = m + 1)
            if (push_v[m])
                fifo_mem[{m[2:0], wptr_reg[m][1:0]}] <= push_dat[m];
    end

    // Ordering: internal update, then bus write, then resets.
    // A bus write in the same cycle as an internal write wins.
    always @(posedge clk_in or negedge resetn_in)
    begin : seq_p
        integer b, k, m;
        if (!resetn_in)
        begin
            for (m = 0; m < 128; m = m + 1)
                cfg_reg[m] <= `LCB_BYTE_ZERO;
            for (b = 0; b < NBLK; b = b + 1)
            begin
                acc0_reg[b]   <= `LCB_BYTE_ZERO;
                acc1_reg[b]   <= `LCB_BYTE_ZERO;
                dat0_reg[b]   <= `LCB_BYTE_ZERO;
                dat1_reg[b]   <= `LCB_BYTE_ZERO;
                count_reg[b]  <= `LCB_BYTE_ZERO;
                period_reg[b] <= `LCB_BYTE_ZERO;
                aux_reg[b]    <= `LCB_BYTE_ZERO;
                stat_reg[b]   <= `LCB_BYTE_ZERO;
                mcell_reg[b]  <= `LCB_BYTE_ZERO;
            end
            for (m = 0; m < 8; m = m + 1)
            begin
                wptr_reg[m] <= 3'h0;
                rptr_reg[m] <= 3'h0;
            end
            carry_reg     <= 4'h0;
            sout_reg      <= 4'h0;
            tc_reg        <= 4'h0;
            route_out     <= 32'h0000_0000;
            bus_rdata_out <= 32'h0000_0000;
            bus_ack_out   <= 1'b0;
            bus_err_out   <= 1'b0;
        end
        else
        begin
            bus_ack_out   <= bus_req_in;
            bus_rdata_out <= bus_rd ? rd_v : 32'h0000_0000;
            bus_err_out   <= bus_req_in & ~(|{lane_v[31], lane_v[23],
                                              lane_v[15], lane_v[7]});
            for (m = 0; m < 8; m = m + 1)
            begin
                wptr_reg[m] <= wptr_reg[m] + {2'b00, push_v[m]};
                rptr_reg[m] <= rptr_reg[m]
                             + {2'b00, bpop_v[m] | ipop_v[m]};
            end
            for (b = 0; b < NBLK; b = b + 1)
            begin
                // Internal activity
                mcell_reg[b] <= rin_v[b*8 +: 8];
                stat_reg[b]  <= mcell_reg[b];
                if (rin_v[b*8 + `LCB_RI_ADD])
                    {carry_reg[b], acc0_reg[b]} <= {1'b0, acc0_reg[b]}
                                                 + {1'b0, dat0_reg[b]};
                if (rin_v[b*8 + `LCB_RI_SHIFT])
                begin
                    sout_reg[b] <= acc1_reg[b][7];
                    acc1_reg[b] <= {acc1_reg[b][6:0],
                                    rin_v[b*8 + `LCB_RI_SIN]};
                end
                // Fifos are the sole dynamic source of data
                if (ipop_v[b*2])
                    dat0_reg[b] <= fifo_mem[{b[1:0], 1'b0,
                                             rptr_reg[b*2][1:0]}];
                if (ipop_v[b*2+1])
                    dat1_reg[b] <= fifo_mem[{b[1:0], 1'b1,
                                             rptr_reg[b*2+1][1:0]}];
                if (aux_reg[b][`LCB_AUX_START])
                begin
                    tc_reg[b] <= (count_reg[b] == `LCB_BYTE_ZERO);
                    count_reg[b] <= (count_reg[b] == `LCB_BYTE_ZERO)
                                  ? period_reg[b]
                                  : count_reg[b] - 8'h01;
                end
                else
                    tc_reg[b] <= 1'b0;
                route_out[b*8 +: 8] <= {tc_reg[b], carry_reg[b],
                                        sout_reg[b], empty_v[b*2],
                                        acc0_reg[b][3:0]};
                // Bus writes
                for (k = 0; k < 4; k = k + 1)
                    if (bus_wr && lane_v[k*8+7]
                        && lane_v[k*8+5 +: 2] == b[1:0])
                    begin
                        if (bus_space_in == `LCB_SP_CFG)
                            cfg_reg[{b[1:0], lane_v[k*8 +: 5]}]
                                <= bus_wdata_in[k*8 +: 8];
                        else
                            case (lane_v[k*8 +: 5])
                                `LCB_R_ACC0:
                                    acc0_reg[b] <= bus_wdata_in[k*8 +: 8];
                                `LCB_R_ACC1:
                                    acc1_reg[b] <= bus_wdata_in[k*8 +: 8];
                                `LCB_R_DAT0:
                                    if (!dload_v[b])
                                        dat0_reg[b] <= bus_wdata_in[k*8 +: 8];
                                `LCB_R_DAT1:
                                    if (!dload_v[b])
                                        dat1_reg[b] <= bus_wdata_in[k*8 +: 8];
                                `LCB_R_COUNT:
                                    count_reg[b] <= bus_wdata_in[k*8 +: 8];
                                `LCB_R_PERIOD:
                                    period_reg[b] <= bus_wdata_in[k*8 +: 8];
                                `LCB_R_AUXCTL:
                                    aux_reg[b] <= bus_wdata_in[k*8 +: 8];
                                default:
                                    aux_reg[b] <= aux_reg[b];
                            endcase
                    end
                // Routed and firmware resets; period and aux never cleared
                if (arr_rst_v[b])
                    mcell_reg[b] <= `LCB_BYTE_ZERO;
                if (cu_rst_v[b])
                begin
                    count_reg[b] <= `LCB_BYTE_ZERO;
                    tc_reg[b]    <= 1'b0;
                end
                if (sr_rst_v[b])
                    stat_reg[b] <= `LCB_BYTE_ZERO;
                if (du_rst_v[b])
                begin
                    acc0_reg[b]  <= `LCB_BYTE_ZERO;
                    acc1_reg[b]  <= `LCB_BYTE_ZERO;
                    carry_reg[b] <= 1'b0;
                    sout_reg[b]  <= 1'b0;
                    route_out[b*8 +: 8] <= `LCB_BYTE_ZERO;
                    wptr_reg[b*2]   <= 3'h0;
                    rptr_reg[b*2]   <= 3'h0;
                    wptr_reg[b*2+1] <= 3'h0;
                    rptr_reg[b*2+1] <= 3'h0;
                end
                // Data registers only follow the firmware reset
                if (fw_rst_v[b])
                begin
                    dat0_reg[b] <= `LCB_BYTE_ZERO;
                    dat1_reg[b] <= `LCB_BYTE_ZERO;
                end
            end
        end
    end

endmodule // lcb_reset_access
